// ---- hw/status_bank.sv ----
/*
 * Alarm and general status bank of a monitor-and-control device.
 * Assumes the converter sequencer gives one-cycle result strobes with
 * codes and window limits, and a one-cycle strobe per conversion round.
 * Pins from outside the clock domain pass two flip-flops first.
 */
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
// Contract
// - Status-0 bits 4..0 flag channels 20..16 outside their threshold window.
// - Reserved bits read constant: status-0 7..5 and status-1 7..4 zero, general bit2 one.
// - Status-1 bit 3 sets when external alarm pin is enabled and high.
// - Status-1 bit 2 sets when die temperature is at or above 150 degC.
// - Thermal flag stays zero while the temperature sensor is disabled.
// - Thermal condition releases only 8 degC below trip level.
// - Status-1 bit 1 sets when local temperature exceeds upper threshold.
// - Status-1 bit 0 sets when local temperature falls below lower threshold.
// - General bits 7..4 show range detectors for groups D, C, B, A.
// - Auto mode: idle reads one, zero once triggered, until converter stops.
// - Direct mode: idle clears at trigger, returns to one when set completes.
// - General bit 1 is OR of alarm flags, held until status read.
// - Reading the status register clears the global alarm summary bit.
// - Direct mode: data-available sets when conversions finish, zero while running.
// - Data-available stays cleared in auto mode.
// - Alarm flag sets only after N consecutive out-of-range conversions; here the external-pin and over-temperature flags set unfiltered.
// - Alarm flags are sticky until read after cause resolves, or reset.
// - Read clears all flags of a register; persistent violations reassert next round.
module status_bank
   import status_bank_pkg::*;
(
   input  wire logic               clk_sys,
   input  wire logic               rst,
   input  wire logic [7:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   input  wire logic               reg_write,
   input  wire logic               reg_read,
   output logic      [7:0]         reg_rdata,
   input  wire logic [3:0]         consec_count,
   input  wire logic [NUM_CHANNELS-1:0] chan_result_valid,
   input  wire logic [11:0]        chan_result [NUM_CHANNELS],
   input  wire logic [11:0]        chan_upper [NUM_CHANNELS],
   input  wire logic [11:0]        chan_lower [NUM_CHANNELS],
   input  wire logic               temp_result_valid,
   input  wire logic signed [11:0] temp_result,
   input  wire logic signed [11:0] temp_upper,
   input  wire logic signed [11:0] temp_lower,
   input  wire logic               temp_sensor_enable,
   input  wire logic               external_alarm_input_pin,
   input  wire logic               external_alarm_enable,
   input  wire logic               group_d_range_detect,
   input  wire logic               group_c_range_detect,
   input  wire logic               group_b_range_detect,
   input  wire logic               group_a_range_detect,
   input  wire logic               direct_mode,
   input  wire logic               conv_trigger,
   input  wire logic               conv_stop,
   input  wire logic               direct_set_done,
   output logic                    irq
);

   // The spare state code falls back to idle through the default branch.
   typedef enum logic [1:0] {
      CONV_IDLE    = 2'b00,
      CONV_AUTO    = 2'b01,
      CONV_DIRECT  = 2'b10
   } conv_state_type;

   // Filtered flag inputs: 0..4 channels, 5 high, 6 low temperature.
   localparam int NUM_FILTERED = NUM_CHANNELS + 2;

   logic [NUM_FILTERED-1:0] filt_valid;
   logic [NUM_FILTERED-1:0] filt_out;
   logic [NUM_FILTERED-1:0] filt_hit;
   logic [3:0]              filt_cnt_reg [NUM_FILTERED];
   logic [4:0]              chan_flag_reg;
   logic [3:0]              temp_flag_reg;
   logic                    summary_reg;
   logic                    available_reg;
   logic                    overtemp_cond_reg;
   logic [1:0]              ext_pin_sync_reg;
   logic [1:0]              ext_en_sync_reg;
   logic [3:0]              range_sync0_reg;
   logic [3:0]              range_sync1_reg;
   logic [3:0]              irq_mask_reg;
   logic [3:0]              irq_status_reg;
   logic [3:0]              irq_event;
   conv_state_type          conv_state_reg;
   logic                    read_chan;
   logic                    read_temp;
   logic                    read_general;
   logic [3:0]              consec_eff;
   logic [4:0]              chan_prev_reg;
   logic [3:0]              temp_prev_reg;
   logic                    ext_alarm_live;
   logic                    overtemp_live;
   logic                    any_new_alarm;
   logic                    idle_flag;
   logic [7:0]              general_word;

   // The read strobe lasts one cycle, so each host read clears a register's
   // flags exactly once.
   assign read_chan    = reg_read && (reg_addr == CHANNEL_ALARM_STATUS_ADDR);
   assign read_temp    = reg_read && (reg_addr == TEMP_PIN_ALARM_STATUS_ADDR);
   assign read_general = reg_read && (reg_addr == GENERAL_STATUS_ADDR);
   // A count of zero would never trip, so it behaves like one.
   assign consec_eff = (consec_count == 4'h0) ? 4'h1 : consec_count;

   // The pin alarm is taken only after both the pin and its enable have passed
   // the synchronisers, so a pulse shorter than one clock may go unnoticed.
   assign ext_alarm_live = ext_pin_sync_reg[1] && ext_en_sync_reg[1];

   // A disabled sensor must never raise the thermal alarm, even while the
   // condition register still holds a trip from before it was switched off.
   assign overtemp_live = overtemp_cond_reg && temp_sensor_enable;

   // Any source that sets a sticky flag in this cycle also sets the summary.
   assign any_new_alarm = (|filt_hit) || ext_alarm_live || overtemp_live;

   assign idle_flag = (conv_state_reg == CONV_IDLE);

   // The reserved bit is tied high, so the word reads 0x0c straight after reset.
   assign general_word = {range_sync1_reg,
                          idle_flag,
                          1'b1,
                          summary_reg,
                          available_reg};

   always_comb begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         filt_valid[i] = chan_result_valid[i];
         filt_out[i]   = (chan_result[i] > chan_upper[i]) ||
                         (chan_result[i] < chan_lower[i]);
      end
      // Temperature limits compare as signed codes, channel limits as unsigned.
      filt_valid[NUM_CHANNELS]   = temp_result_valid && temp_sensor_enable;
      filt_out[NUM_CHANNELS]     = temp_result > temp_upper;
      filt_valid[NUM_CHANNELS+1] = temp_result_valid && temp_sensor_enable;
      filt_out[NUM_CHANNELS+1]   = temp_result < temp_lower;
   end

   // Consecutive out-of-range counter per input; any in-range result restarts it.
   // The count stops at N, so it never wraps however long a fault lasts.
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < NUM_FILTERED; i++) begin
         if (rst) begin
            filt_cnt_reg[i] <= 4'h0;
         end else if (filt_valid[i]) begin
            if (!filt_out[i]) begin
               filt_cnt_reg[i] <= 4'h0;
            end else if (filt_cnt_reg[i] < consec_eff) begin
               filt_cnt_reg[i] <= filt_cnt_reg[i] + 4'h1;
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_FILTERED; i++) begin
         // The count is held against N-1 so that the Nth consecutive result sets
         // the flag itself; a lasting violation keeps re-arming its flag after reads.
         filt_hit[i] = filt_valid[i] && filt_out[i] &&
                       (filt_cnt_reg[i] >= (consec_eff - 4'h1));
      end
   end

   // The pin, its enable and the range detectors are slow outside levels; two
   // stages keep metastability away from the flags.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ext_pin_sync_reg <= 2'b00;
         ext_en_sync_reg  <= 2'b00;
         range_sync0_reg  <= 4'h0;
         range_sync1_reg  <= 4'h0;
      end else begin
         ext_pin_sync_reg <= {ext_pin_sync_reg[0], external_alarm_input_pin};
         ext_en_sync_reg  <= {ext_en_sync_reg[0], external_alarm_enable};
         range_sync0_reg  <= {group_d_range_detect, group_c_range_detect,
                              group_b_range_detect, group_a_range_detect};
         range_sync1_reg  <= range_sync0_reg;
      end
   end

   // Over-temperature condition with hysteresis, cleared while the sensor is off.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         overtemp_cond_reg <= 1'b0;
      end else if (!temp_sensor_enable) begin
         overtemp_cond_reg <= 1'b0;
      end else if (temp_result_valid) begin
         if (temp_result >= OVERTEMP_TRIP_CODE) begin
            overtemp_cond_reg <= 1'b1;
         end else if (temp_result <= OVERTEMP_RELEASE_CODE) begin
            overtemp_cond_reg <= 1'b0;
         end
      end
   end

   // Sticky flags: a read clears, but a new hit in the same cycle wins.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         chan_flag_reg <= CHANNEL_ALARM_RESET[4:0];
      end else begin
         chan_flag_reg <= (read_chan ? 5'h00 : chan_flag_reg) |
                          filt_hit[NUM_CHANNELS-1:0];
      end
   end

   // The thermal bit has no filter of its own: the hysteresis on its condition
   // already keeps it from chattering.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         temp_flag_reg <= TEMP_PIN_ALARM_RESET[3:0];
      end else begin
         temp_flag_reg[EXT_ALARM_BIT] <= (temp_flag_reg[EXT_ALARM_BIT] && !read_temp) ||
            ext_alarm_live;
         temp_flag_reg[OVERTEMP_BIT] <= temp_sensor_enable &&
            ((temp_flag_reg[OVERTEMP_BIT] && !read_temp) ||
             overtemp_cond_reg);
         temp_flag_reg[TEMP_HIGH_BIT] <= (temp_flag_reg[TEMP_HIGH_BIT] && !read_temp) ||
            filt_hit[NUM_CHANNELS];
         temp_flag_reg[TEMP_LOW_BIT] <= (temp_flag_reg[TEMP_LOW_BIT] && !read_temp) ||
            filt_hit[NUM_CHANNELS+1];
      end
   end

   // Summary holds until the general status is read; a live flag re-arms it.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         summary_reg <= GENERAL_STATUS_RESET[SUMMARY_BIT];
      end else if (any_new_alarm) begin
         summary_reg <= 1'b1;
      end else if (read_general) begin
         summary_reg <= 1'b0;
      end else if ((|chan_flag_reg) || (|temp_flag_reg)) begin
         summary_reg <= 1'b1;
      end
   end

   // A trigger while converting is ignored, and each mode leaves only by its
   // own exit: changing direct_mode in mid-run does not end a conversion.
   // A stop in direct mode abandons the set, so no results are marked fresh.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         conv_state_reg <= CONV_IDLE;
      end else begin
         case (conv_state_reg)
            CONV_IDLE: begin
               if (conv_trigger) begin
                  conv_state_reg <= direct_mode ? CONV_DIRECT : CONV_AUTO;
               end
            end
            CONV_AUTO: begin
               if (conv_stop) begin
                  conv_state_reg <= CONV_IDLE;
               end
            end
            CONV_DIRECT: begin
               if (direct_set_done || conv_stop) begin
                  conv_state_reg <= CONV_IDLE;
               end
            end
            default: begin
               conv_state_reg <= CONV_IDLE;
            end
         endcase
      end
   end

   // Fresh-data flag: only direct mode can set it, and a new trigger withdraws
   // it until that set completes.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         available_reg <= GENERAL_STATUS_RESET[AVAILABLE_BIT];
      end else if (!direct_mode || conv_state_reg == CONV_AUTO) begin
         available_reg <= 1'b0;
      end else if (conv_state_reg == CONV_DIRECT && direct_set_done) begin
         available_reg <= 1'b1;
      end else if (conv_trigger || conv_state_reg == CONV_DIRECT) begin
         available_reg <= 1'b0;
      end
   end

   // Interrupt events fire on each rising sticky flag.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         chan_prev_reg <= 5'h00;
         temp_prev_reg <= 4'h0;
      end else begin
         chan_prev_reg <= chan_flag_reg;
         temp_prev_reg <= temp_flag_reg;
      end
   end

   assign irq_event[0] = |(chan_flag_reg & ~chan_prev_reg);
   assign irq_event[1] = |(temp_flag_reg & ~temp_prev_reg);
   assign irq_event[2] = (conv_state_reg == CONV_DIRECT) && direct_set_done;
   assign irq_event[3] = (conv_state_reg == CONV_AUTO) && conv_stop;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq_mask_reg <= IRQ_MASK_RESET;
      end else if (reg_write && reg_addr == IRQ_MASK_ADDR) begin
         irq_mask_reg <= reg_wdata[3:0];
      end
   end

   // Write-one-to-clear; an event in the same cycle as the clear still lands,
   // so software never loses a completion that races its own acknowledge.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq_status_reg <= 4'h0;
      end else if (reg_write && reg_addr == IRQ_STATUS_ADDR) begin
         irq_status_reg <= (irq_status_reg & ~reg_wdata[3:0]) | irq_event;
      end else begin
         irq_status_reg <= irq_status_reg | irq_event;
      end
   end

   // The event term is included here so the line rises one cycle after the
   // event rather than two.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_status_reg | irq_event) & irq_mask_reg);
      end
   end

   // Read data stands only in the cycle after the strobe; unmapped reads zero.
   // The address is decoded in full, so aliases of the status registers read zero.
   always_ff @(posedge clk_sys) begin
      if (rst || !reg_read) begin
         reg_rdata <= 8'h00;
      end else begin
         case (reg_addr)
            CHANNEL_ALARM_STATUS_ADDR:  reg_rdata <= {3'b000, chan_flag_reg};
            TEMP_PIN_ALARM_STATUS_ADDR: reg_rdata <= {4'h0, temp_flag_reg};
            GENERAL_STATUS_ADDR:        reg_rdata <= general_word;
            IRQ_MASK_ADDR:              reg_rdata <= {4'h0, irq_mask_reg};
            IRQ_STATUS_ADDR:            reg_rdata <= {4'h0, irq_status_reg};
            default:                    reg_rdata <= 8'h00;
         endcase
      end
   end

endmodule : status_bank

// ---- inc/status_bank_pkg.sv ----
/*
 * Constants shared by the alarm and general status bank: register offsets,
 * field positions, reset values, filter count and temperature limits.
 * Assumes 12-bit converter codes and a 12-bit two's complement temperature
 * reading at 0.125 degC per code.
 */
package status_bank_pkg;
   localparam logic [7:0]  CHANNEL_ALARM_STATUS_ADDR = 8'h70;
   localparam logic [7:0]  TEMP_PIN_ALARM_STATUS_ADDR = 8'h71;
   localparam logic [7:0]  GENERAL_STATUS_ADDR       = 8'h72;
   localparam logic [7:0]  IRQ_MASK_ADDR             = 8'h74;
   localparam logic [7:0]  IRQ_STATUS_ADDR           = 8'h75;
   localparam logic [7:0]  CHANNEL_ALARM_RESET       = 8'h00;
   localparam logic [7:0]  TEMP_PIN_ALARM_RESET      = 8'h00;
   localparam logic [7:0]  GENERAL_STATUS_RESET      = 8'h0c;
   localparam int          NUM_CHANNELS              = 5;
   localparam int          EXT_ALARM_BIT             = 3;
   localparam int          OVERTEMP_BIT              = 2;
   localparam int          TEMP_HIGH_BIT             = 1;
   localparam int          TEMP_LOW_BIT              = 0;
   localparam int          IDLE_BIT                  = 3;
   localparam int          RESERVED_ONE_BIT          = 2;
   localparam int          SUMMARY_BIT               = 1;
   localparam int          AVAILABLE_BIT             = 0;
   localparam logic [3:0]  CONSEC_COUNT_DEFAULT      = 4'h4;
   localparam int          TEMP_CODES_PER_DEGC       = 8;
   localparam int          OVERTEMP_TRIP_DEGC        = 150;
   localparam int          OVERTEMP_HYST_DEGC        = 8;
   localparam logic signed [11:0] OVERTEMP_TRIP_CODE =
      12'(OVERTEMP_TRIP_DEGC * TEMP_CODES_PER_DEGC);
   localparam logic signed [11:0] OVERTEMP_RELEASE_CODE =
      12'((OVERTEMP_TRIP_DEGC - OVERTEMP_HYST_DEGC) * TEMP_CODES_PER_DEGC);
   localparam logic [3:0]  IRQ_MASK_RESET            = 4'h0;
endpackage : status_bank_pkg

// ---- verification/status_bank_assertions.sv ----
/* Concurrent checks on the status bank register port and flags.
   Assumes one clock domain and the bank package for offsets. */
`timescale 1ns/1ns
module status_bank_assertions
   import status_bank_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic       external_alarm_input_pin,
   input wire logic       external_alarm_enable,
   input wire logic       group_d_range_detect,
   input wire logic       group_c_range_detect,
   input wire logic       group_b_range_detect,
   input wire logic       group_a_range_detect,
   input wire logic       direct_mode,
   input wire logic       conv_trigger,
   input wire logic       conv_stop,
   input wire logic       direct_set_done,
   input wire logic       irq
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   sequence rd_at(logic [7:0] a);
      reg_read && reg_addr == a;
   endsequence
   sequence quiet_ctl;
      !conv_stop && !direct_set_done;
   endsequence
   res0_zero_a: assert property (rd_at(CHANNEL_ALARM_STATUS_ADDR) |=> reg_rdata[7:5] == 3'h0)
      else $error("status 0 reserved bits not zero");
   res1_zero_a: assert property (rd_at(TEMP_PIN_ALARM_STATUS_ADDR) |=> reg_rdata[7:4] == 4'h0)
      else $error("status 1 reserved bits not zero");
   gen_one_a: assert property (rd_at(GENERAL_STATUS_ADDR) |=> reg_rdata[2])
      else $error("general reserved bit not one");
   range_map_a: assert property ($stable({group_d_range_detect, group_c_range_detect,
      group_b_range_detect, group_a_range_detect})[*4] ##0 rd_at(GENERAL_STATUS_ADDR)
      |=> reg_rdata[7:4] == $past({group_d_range_detect, group_c_range_detect,
      group_b_range_detect, group_a_range_detect}))
      else $error("range detect bits wrong");
   auto_avail_a: assert property ((!direct_mode)[*2] ##0 rd_at(GENERAL_STATUS_ADDR)
      |=> !reg_rdata[0])
      else $error("data available set in auto mode");
   ext_flag_a: assert property ((external_alarm_input_pin && external_alarm_enable)[*6]
      ##0 rd_at(TEMP_PIN_ALARM_STATUS_ADDR) |=> reg_rdata[3])
      else $error("external alarm flag missing");
   trig_idle_a: assert property ((conv_trigger and quiet_ctl) ##1 quiet_ctl
      ##1 (quiet_ctl and rd_at(GENERAL_STATUS_ADDR)) |=> !reg_rdata[3])
      else $error("idle still set after trigger");
   irq_mask_a: assert property ((reg_write && reg_addr == IRQ_MASK_ADDR && reg_wdata == 8'h00)
      ##1 !(reg_write && reg_addr == IRQ_MASK_ADDR) |=> !irq)
      else $error("interrupt high with mask clear");
endmodule : status_bank_assertions

bind status_bank status_bank_assertions u_chk (.clk_sys, .rst, .reg_addr, .reg_wdata,
   .reg_write, .reg_read, .reg_rdata, .external_alarm_input_pin, .external_alarm_enable,
   .group_d_range_detect, .group_c_range_detect, .group_b_range_detect,
   .group_a_range_detect, .direct_mode, .conv_trigger, .conv_stop, .direct_set_done, .irq);

// ---- verification/host_model.sv ----
/* Host controller model that reads and writes the status bank registers.
   Assumes one-cycle strobes and read data standing the cycle after. */
`timescale 1ns/1ns
module host_model (
   input  wire logic       clk_sys,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_write,
   output logic            reg_read,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'hff;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   // Idle address and data are inverted so a stale value never looks valid.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_write <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      reg_addr <= ~a;
      // Taken at the next edge, before that edge overwrites the read data.
      @(posedge clk_sys);
      d = reg_rdata;
   endtask : rd
endmodule : host_model

// ---- verification/alarm_and_general_status_bank_tb.sv ----
/* Self-checking bench for the status bank.
   Assumes the host model drives the register port; converter strobes come from here. */
`timescale 1ns/1ns
module alarm_and_general_status_bank_tb
   import status_bank_pkg::*;
;
   logic clk_sys = 1'b0, rst = 1'b1, temp_result_valid = 1'b0, temp_sensor_enable = 1'b1;
   logic ext_pin = 1'b0, ext_en = 1'b0, gd = 1'b0, gc = 1'b0, gb = 1'b0, ga = 1'b0;
   logic direct_mode = 1'b0, conv_trigger = 1'b0, conv_stop = 1'b0, direct_set_done = 1'b0;
   logic [3:0] consec_count = 4'h3;
   logic [NUM_CHANNELS-1:0] chan_result_valid = '0;
   logic [11:0] chan_result [NUM_CHANNELS] = '{default: 12'h000};
   logic [11:0] chan_upper [NUM_CHANNELS] = '{default: 12'h0c8};
   logic [11:0] chan_lower [NUM_CHANNELS] = '{default: 12'h064};
   // Temperature codes are eighths of a degree: 0x4b0 is 150 degC.
   logic signed [11:0] temp_result = 12'h000, temp_upper = 12'h190, temp_lower = 12'hfb0;
   wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
   wire logic reg_write, reg_read, irq;
   int checks = 0, fails = 0;
   always #10 clk_sys = ~clk_sys;
   host_model u_host (.clk_sys, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
   status_bank u_dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .consec_count, .chan_result_valid, .chan_result, .chan_upper, .chan_lower,
      .temp_result_valid, .temp_result, .temp_upper, .temp_lower, .temp_sensor_enable,
      .external_alarm_input_pin(ext_pin), .external_alarm_enable(ext_en),
      .group_d_range_detect(gd), .group_c_range_detect(gc), .group_b_range_detect(gb),
      .group_a_range_detect(ga), .direct_mode, .conv_trigger, .conv_stop, .direct_set_done,
      .irq);
   task automatic conclude();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_host.rd(a, d);
      check(d, exp);
   endtask : rdc
   task automatic irqc(input logic exp);
      repeat (2) @(posedge clk_sys);
      #1 check({7'h00, irq}, {7'h00, exp});
   endtask : irqc
   task automatic conv(input logic [11:0] v);
      @(posedge clk_sys);
      foreach (chan_result[i]) chan_result[i] <= v;
      chan_result_valid <= 5'h1f;
      @(posedge clk_sys);
      chan_result_valid <= 5'h00;
   endtask : conv
   task automatic temp(input logic [11:0] v);
      @(posedge clk_sys);
      temp_result <= v;
      temp_result_valid <= 1'b1;
      @(posedge clk_sys);
      temp_result_valid <= 1'b0;
   endtask : temp
   task automatic ctl(input logic [2:0] p);
      @(posedge clk_sys);
      {conv_trigger, conv_stop, direct_set_done} <= p;
      @(posedge clk_sys);
      {conv_trigger, conv_stop, direct_set_done} <= 3'h0;
   endtask : ctl
   task automatic t_reset();
      rdc(8'h70, 8'h00);
      rdc(8'h71, 8'h00);
      rdc(8'h72, 8'h0c);
      u_host.wr(8'h70, 8'hff);
      rdc(8'h70, 8'h00);
      rdc(8'h7f, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_range();
      {gd, gc, gb, ga} <= 4'ha;
      repeat (4) @(posedge clk_sys);
      rdc(8'h72, 8'hac);
      {gd, gc, gb, ga} <= 4'h5;
      repeat (4) @(posedge clk_sys);
      rdc(8'h72, 8'h5c);
      {gd, gc, gb, ga} <= 4'h0;
      repeat (4) @(posedge clk_sys);
      $display("test range done");
   endtask : t_range
   task automatic t_modes();
      ctl(3'h4);
      rdc(8'h72, 8'h04);
      ctl(3'h1);
      rdc(8'h72, 8'h04);
      ctl(3'h2);
      rdc(8'h72, 8'h0c);
      direct_mode <= 1'b1;
      ctl(3'h4);
      rdc(8'h72, 8'h04);
      ctl(3'h1);
      rdc(8'h72, 8'h0d);
      ctl(3'h4);
      rdc(8'h72, 8'h04);
      ctl(3'h1);
      direct_mode <= 1'b0;
      rdc(8'h72, 8'h0c);
      $display("test modes done");
   endtask : t_modes
   task automatic t_chan();
      u_host.wr(8'h75, 8'h0f);
      conv(12'h12c);
      conv(12'h12c);
      conv(12'h096);
      conv(12'h12c);
      conv(12'h12c);
      rdc(8'h70, 8'h00);
      conv(12'h032);
      irqc(1'b0);
      u_host.wr(8'h74, 8'h01);
      irqc(1'b1);
      rdc(8'h75, 8'h01);
      u_host.wr(8'h75, 8'h01);
      irqc(1'b0);
      u_host.wr(8'h74, 8'h00);
      rdc(8'h70, 8'h1f);
      conv(12'h12c);
      rdc(8'h70, 8'h1f);
      conv(12'h096);
      rdc(8'h70, 8'h00);
      rdc(8'h72, 8'h0e);
      rdc(8'h72, 8'h0c);
      $display("test channels done");
   endtask : t_chan
   task automatic t_temp();
      consec_count <= 4'h1;
      temp(12'h4b0);
      rdc(8'h71, 8'h06);
      temp(12'h474);
      rdc(8'h71, 8'h06);
      rdc(8'h71, 8'h04);
      temp(12'h470);
      rdc(8'h71, 8'h06);
      rdc(8'h71, 8'h00);
      temp(12'hf9c);
      rdc(8'h71, 8'h01);
      temp_sensor_enable <= 1'b0;
      temp(12'h514);
      rdc(8'h71, 8'h00);
      temp_sensor_enable <= 1'b1;
      $display("test temperature done");
   endtask : t_temp
   task automatic t_ext();
      ext_pin <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rdc(8'h71, 8'h00);
      ext_en <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rdc(8'h71, 8'h08);
      ext_pin <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rdc(8'h71, 8'h08);
      rdc(8'h71, 8'h00);
      $display("test external done");
   endtask : t_ext
   initial begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_range();
      t_modes();
      t_chan();
      t_temp();
      t_ext();
      conclude();
   end
   // The full sequence needs well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge clk_sys);
      fails++;
      conclude();
   end
endmodule : alarm_and_general_status_bank_tb
